/* core/ulb_pkg.sv */
// Package for the link power and endpoint buffer control block.
// Holds register addresses, field positions, widths and reset values.
// Assumes the APB fabric presents full 32-bit byte addresses.
package ulb_pkg;

  // Register byte addresses.
  localparam logic [31:0] ULB_ADDR_LPC      = 32'h40080010;
  localparam logic [31:0] ULB_ADDR_ABORT    = 32'h40080014;
  localparam logic [31:0] ULB_ADDR_SEL      = 32'h40080018;
  localparam logic [31:0] ULB_ADDR_MODE     = 32'h4008001c;
  localparam logic [31:0] ULB_ADDR_IRQ_STAT = 32'h40080040;
  localparam logic [31:0] ULB_ADDR_IRQ_CLR  = 32'h40080044;
  localparam logic [31:0] ULB_ADDR_IRQ_EN   = 32'h40080048;

  // Field positions and widths.
  localparam int ULB_HIRD_W       = 4;
  localparam int ULB_RESUME_DURATION_FROM_HOST_LSB  = 0;
  localparam int ULB_DEVICE_RESUME_DURATION_LSB  = 4;
  localparam int ULB_PEND_BIT     = 8;
  localparam int ULB_NUM_EP       = 10;
  localparam int ULB_NUM_ABORT    = 30;
  localparam int ULB_NUM_IRQ      = 11;
  localparam int ULB_IRQ_LPM_BIT  = 10;

  // Reset values.
  localparam logic [3:0]  ULB_RST_HIRD   = 4'h0;
  localparam logic        ULB_RST_PEND   = 1'b0;
  localparam logic [29:0] ULB_RST_ABORT  = 30'h0;
  localparam logic [9:0]  ULB_RST_EP     = 10'h0;
  localparam logic [10:0] ULB_RST_IRQ    = 11'h0;
  localparam logic [31:0] ULB_RST_WORD   = 32'h0;

  // Endpoint zero directions are always single buffered.
  localparam logic [9:0]  ULB_EP_WR_MASK = 10'h3fc;

  // Clears the endpoint zero bits and widens to a bus word.
  function automatic logic [31:0] ulb_ep_word(input logic [9:0] v);
    ulb_ep_word = {22'h0, v & ULB_EP_WR_MASK};
  endfunction

endpackage

/* core/ulb_irq_ctrl.sv */
// Sticky interrupt status with enable and write-one-to-clear.
// Assumes clear and enable writes arrive as one-cycle strobes from the bus slave.
`timescale 1ns/10ps
module ulb_irq_ctrl (
  // Clock and reset.
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // Event and software controls.
  input  wire logic [ulb_pkg::ULB_NUM_IRQ-1:0] event_set,
  input  wire logic                          clear_wr,
  input  wire logic [ulb_pkg::ULB_NUM_IRQ-1:0] clear_bits,
  input  wire logic                          enable_wr,
  input  wire logic [ulb_pkg::ULB_NUM_IRQ-1:0] enable_bits,
  // State and interrupt.
  output logic      [ulb_pkg::ULB_NUM_IRQ-1:0] status,
  output logic      [ulb_pkg::ULB_NUM_IRQ-1:0] enable,
  output logic                               irq
);
  import ulb_pkg::*;

  logic [ULB_NUM_IRQ-1:0] status_q;
  logic [ULB_NUM_IRQ-1:0] status_d;
  logic [ULB_NUM_IRQ-1:0] enable_q;
  logic                   irq_q;

  // A new event beats a clear that lands in the same cycle.
  always_comb begin
    status_d = (status_q & ~(clear_wr ? clear_bits : ULB_RST_IRQ)) | event_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= ULB_RST_IRQ;
    end else begin
      status_q <= status_d;
    end
  end

  // Enable register written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= ULB_RST_IRQ;
    end else if (enable_wr) begin
      enable_q <= enable_bits;
    end
  end

  // The line follows the next status, so it rises with the status bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & (enable_wr ? enable_bits : enable_q));
    end
  end

  assign status = status_q;
  assign enable = enable_q;
  assign irq    = irq_q;

  a_event_sets_status: assert property (@(posedge pclk) disable iff (!presetn)
    (event_set != 0) |=> ((status_q & $past(event_set)) == $past(event_set)))
    else $error("Event did not set its status bit.");

  a_irq_follows_status: assert property (@(posedge pclk) disable iff (!presetn)
    irq_q == (|(status_q & enable_q)))
    else $error("Interrupt line disagrees with enabled status.");

endmodule // ulb_irq_ctrl

/* core/ulb_ctrl.sv */
// Link power handshake and endpoint buffer control for a full-speed device.
// Assumes a zero-wait-capable APB master and a list engine on the same clock
// that reports buffer deactivations as one-cycle pulses.
//
// Notes on behaviour
// - Each received power token's 4-bit host resume duration is stored, replacing the last one.
// - Software owns a 4-bit device resume duration field in bits 7 to 4.
// - With power management supported and data pending set, every token gets a NYET.
// - With power management supported and data pending clear, every token gets an ACK.
// - Writing one to an abort bit asks the engine to deactivate that endpoint's buffer.
// - When the engine reports the deactivation the abort bit clears and buffer select stays.
// - An endpoint interrupt is raised whenever a buffer's Active bit falls, aborts on abort bits 9 to 0 included.
// - On a double-buffered abort only the buffer named by buffer select is deactivated.
// - One buffer select bit per physical endpoint sits in bits 9 to 2.
// - The endpoint zero select and mode bits read zero and cannot be written.
// - One double buffer enable bit per physical endpoint sits in bits 9 to 2.
// - A single-buffered endpoint keeps its buffer select when its Active bit clears.
// - A double-buffered endpoint toggles its buffer select each time its Active bit clears by byte count.
// - The endpoint status bit is set when the Active bit clears by count or by abort.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
module ulb_ctrl (
  // Clock and reset.
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // APB slave.
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [31:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // Link power token interface.
  input  wire logic                                lpm_supported,
  input  wire logic                                lpm_token_valid,
  input  wire logic [ulb_pkg::ULB_HIRD_W-1:0]      lpm_token_hird,
  output logic                                     lpm_hs_valid,
  output logic                                     lpm_hs_nyet,
  output logic      [ulb_pkg::ULB_HIRD_W-1:0]      device_resume_duration,
  // Endpoint buffer interface to the list engine.
  input  wire logic [ulb_pkg::ULB_NUM_EP-1:0]      nbytes_done,
  input  wire logic [ulb_pkg::ULB_NUM_ABORT-1:0]   abort_done,
  output logic      [ulb_pkg::ULB_NUM_ABORT-1:0]   abort_request,
  output logic      [ulb_pkg::ULB_NUM_EP-1:0]      active_buffer_select,
  output logic      [ulb_pkg::ULB_NUM_EP-1:0]      double_buffer_enable,
  // Interrupt.
  output logic                                     irq
);
  import ulb_pkg::*;

  // Bus state.
  logic                     pready_q;
  logic                     pslverr_q;
  logic [31:0]              prdata_q;
  logic                     wr_en;
  logic                     setup;
  logic                     mapped;

  // Register state.
  logic [ULB_HIRD_W-1:0]    resume_duration_from_host_q;
  logic [ULB_HIRD_W-1:0]    device_resume_duration_q;
  logic                     pending_q;
  logic [ULB_NUM_ABORT-1:0] abort_q;
  logic [ULB_NUM_ABORT-1:0] abort_d;
  logic [ULB_NUM_EP-1:0]    sel_q;
  logic [ULB_NUM_EP-1:0]    sel_d;
  logic [ULB_NUM_EP-1:0]    dbl_q;
  logic [ULB_NUM_EP-1:0]    toggle;
  logic                     hs_valid_q;
  logic                     hs_nyet_q;

  // Interrupt wiring.
  logic [ULB_NUM_IRQ-1:0]   irq_event;
  logic [ULB_NUM_IRQ-1:0]   irq_status;
  logic [ULB_NUM_IRQ-1:0]   irq_enable;

  // Register write strobes, one per writable register.
  logic                     wr_lpc;
  logic                     wr_abort;
  logic                     wr_sel;
  logic                     wr_mode;
  logic                     wr_irq_clr;
  logic                     wr_irq_en;

  // A write takes effect only at the edge that completes the access phase.
  assign setup      = psel && !penable;
  assign wr_en      = psel && penable && pwrite && pready_q;
  assign wr_lpc     = wr_en && (paddr == ULB_ADDR_LPC);
  assign wr_abort   = wr_en && (paddr == ULB_ADDR_ABORT);
  assign wr_sel     = wr_en && (paddr == ULB_ADDR_SEL);
  assign wr_mode    = wr_en && (paddr == ULB_ADDR_MODE);
  assign wr_irq_clr = wr_en && (paddr == ULB_ADDR_IRQ_CLR);
  assign wr_irq_en  = wr_en && (paddr == ULB_ADDR_IRQ_EN);

  // Address decode for the error answer.
  always_comb begin
    if (paddr == ULB_ADDR_LPC) begin
      mapped = 1'b1;
    end else if (paddr == ULB_ADDR_ABORT) begin
      mapped = 1'b1;
    end else if (paddr == ULB_ADDR_SEL) begin
      mapped = 1'b1;
    end else if (paddr == ULB_ADDR_MODE) begin
      mapped = 1'b1;
    end else if (paddr == ULB_ADDR_IRQ_STAT) begin
      mapped = 1'b1;
    end else if (paddr == ULB_ADDR_IRQ_CLR) begin
      mapped = 1'b1;
    end else if (paddr == ULB_ADDR_IRQ_EN) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // Ready rises for one access cycle after every setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
    end
  end

  // reserved bits zero
  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= ULB_RST_WORD;
    end else if (setup) begin
      if (pwrite) begin
        prdata_q <= ULB_RST_WORD;
      end else if (paddr == ULB_ADDR_LPC) begin
        prdata_q <= {23'h0, pending_q, device_resume_duration_q, resume_duration_from_host_q};
      end else if (paddr == ULB_ADDR_ABORT) begin
        prdata_q <= {2'h0, abort_q};
      end else if (paddr == ULB_ADDR_SEL) begin
        prdata_q <= ulb_ep_word(sel_q);
      end else if (paddr == ULB_ADDR_MODE) begin
        prdata_q <= ulb_ep_word(dbl_q);
      end else if (paddr == ULB_ADDR_IRQ_STAT) begin
        prdata_q <= {21'h0, irq_status};
      end else if (paddr == ULB_ADDR_IRQ_EN) begin
        prdata_q <= {21'h0, irq_enable};
      end else begin
        prdata_q <= ULB_RST_WORD;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_duration_from_host_q <= ULB_RST_HIRD;
    end else if (lpm_token_valid) begin
      resume_duration_from_host_q <= lpm_token_hird;
    end
  end

  // device duration field
  // The pending bit rides in the same register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_resume_duration_q <= ULB_RST_HIRD;
      pending_q <= ULB_RST_PEND;
    end else if (wr_lpc) begin
      device_resume_duration_q <= pwdata[ULB_DEVICE_RESUME_DURATION_LSB +: ULB_HIRD_W];
      pending_q <= pwdata[ULB_PEND_BIT];
    end
  end

  // ACK when idle
  // A handshake is issued only when power management is supported.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_valid_q <= 1'b0;
      hs_nyet_q  <= 1'b0;
    end else begin
      hs_valid_q <= lpm_token_valid && lpm_supported;
      if (lpm_token_valid && lpm_supported) begin
        hs_nyet_q <= pending_q;
      end
    end
  end

  // clear on done
  // A software request in the same cycle as a completion keeps the bit set.
  always_comb begin
    abort_d = (abort_q & ~abort_done) | (wr_abort ? pwdata[ULB_NUM_ABORT-1:0] : ULB_RST_ABORT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_q <= ULB_RST_ABORT;
    end else begin
      abort_q <= abort_d;
    end
  end

  // abort keeps select
  // Only byte-count completions toggle; abort completions leave the select alone.
  always_comb begin
    toggle = nbytes_done & dbl_q;
    sel_d  = ((wr_sel ? pwdata[ULB_NUM_EP-1:0] : sel_q) ^ toggle) & ULB_EP_WR_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= ULB_RST_EP;
    end else begin
      sel_q <= sel_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbl_q <= ULB_RST_EP;
    end else if (wr_mode) begin
      dbl_q <= pwdata[ULB_NUM_EP-1:0] & ULB_EP_WR_MASK;
    end
  end

  // endpoint bit order
  // Status bit n belongs to physical endpoint n; the top bit marks a power token.
  assign irq_event = {lpm_token_valid, nbytes_done | abort_done[ULB_NUM_EP-1:0]};

  ulb_irq_ctrl u_irq (
    .pclk        (pclk),
    .presetn     (presetn),
    .event_set   (irq_event),
    .clear_wr    (wr_irq_clr),
    .clear_bits  (pwdata[ULB_NUM_IRQ-1:0]),
    .enable_wr   (wr_irq_en),
    .enable_bits (pwdata[ULB_NUM_IRQ-1:0]),
    .status      (irq_status),
    .enable      (irq_enable),
    .irq         (irq)
  );

  // select steers engine
  // Outputs straight from the register flops.
  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign lpm_hs_valid           = hs_valid_q;
  assign lpm_hs_nyet            = hs_nyet_q;
  assign device_resume_duration = device_resume_duration_q;
  assign abort_request          = abort_q;
  assign active_buffer_select   = sel_q;
  assign double_buffer_enable   = dbl_q;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_token_ready;
    lpm_token_valid && lpm_supported;
  endsequence

  sequence s_lpc_write;
    wr_lpc;
  endsequence

  a_hird_capture: assert property (
    lpm_token_valid |=> (resume_duration_from_host_q == $past(lpm_token_hird)))
    else $error("Host resume duration not captured.");

  a_device_resume_duration_write: assert property (
    s_lpc_write |=> (device_resume_duration == $past(pwdata[7:4])))
    else $error("Device resume duration not written.");

  a_lpm_nyet: assert property (
    (s_token_ready and pending_q) |=> (lpm_hs_valid && lpm_hs_nyet))
    else $error("Pending token not answered with NYET.");

  a_lpm_ack: assert property (
    (s_token_ready and !pending_q) |=> (lpm_hs_valid && !lpm_hs_nyet))
    else $error("Idle token not answered with ACK.");

  a_abort_clears: assert property (
    ((abort_done != 0) && !wr_abort) |=> ((abort_q & $past(abort_done)) == 30'h0))
    else $error("Abort bit not cleared after completion.");

  a_abort_keeps_sel: assert property (
    ((abort_done != 0) && (nbytes_done == 0) && !wr_sel) |=> $stable(sel_q))
    else $error("Abort changed the buffer select.");

  a_single_no_toggle: assert property (
    ((nbytes_done & ~dbl_q) != 0 && !wr_sel)
      |=> (((sel_q ^ $past(sel_q)) & $past(nbytes_done & ~dbl_q)) == 10'h0))
    else $error("Single buffered endpoint toggled its select.");

  a_double_toggle: assert property (
    ((nbytes_done & dbl_q) != 0 && !wr_sel)
      |=> (((sel_q ^ $past(sel_q)) & $past(nbytes_done & dbl_q))
        == $past(nbytes_done & dbl_q)))
    else $error("Double buffered endpoint did not toggle.");

  a_ep0_fixed: assert property (
    (sel_q[1:0] == 2'h0) && (dbl_q[1:0] == 2'h0))
    else $error("Endpoint zero select or mode bits set.");

  a_mode_read_zero: assert property (
    (setup && !pwrite && (paddr == ULB_ADDR_MODE)) |=> (prdata[31:10] == 22'h0)
      && pready)
    else $error("Reserved mode bits read nonzero.");

  a_apb_ready_once: assert property (
    setup |=> pready ##1 (!pready || $past(setup)))
    else $error("Ready did not follow setup by one cycle.");

  a_abort_sets: assert property (
    wr_abort |=> ((abort_q & $past(pwdata[ULB_NUM_ABORT-1:0]))
      == $past(pwdata[ULB_NUM_ABORT-1:0])))
    else $error("Abort request bit not set by write.");

  a_hs_needs_token: assert property (
    lpm_hs_valid |-> $past(lpm_token_valid && lpm_supported))
    else $error("Handshake issued without a supported token.");

  a_ep_event_status: assert property (
    ((nbytes_done | abort_done[ULB_NUM_EP-1:0]) != 0)
      |=> ((irq_status[ULB_NUM_EP-1:0] & $past(nbytes_done | abort_done[ULB_NUM_EP-1:0]))
        == $past(nbytes_done | abort_done[ULB_NUM_EP-1:0])))
    else $error("Deactivation did not set the endpoint status bit.");

  a_unmapped_error: assert property (
    (setup && !mapped) |=> (pready && pslverr && (prdata == 32'h0)))
    else $error("Unmapped access not answered with an error.");

endmodule // ulb_ctrl

/* verification/ulb_host_model.sv */
// Far-side model: a host that sends power tokens and a list engine that completes aborts.
// Assumes the device clock times both sides and every pulse lasts one cycle.
`timescale 1ns/10ps
module ulb_host_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Engine side.
  input  wire logic [29:0] abort_request,
  input  wire logic [7:0]  dly,
  output logic      [29:0] abort_done,
  // Host token side.
  output logic             lpm_token_valid,
  output logic      [3:0]  lpm_token_hird
);
  int cnt;

  // The token lines idle low and the duration lines show a changed value between tokens.
  initial begin
    lpm_token_valid = 1'b0;
    lpm_token_hird  = 4'h0;
  end

  // Sends one power token carrying a host resume duration.
  task automatic send_token(input logic [3:0] h);
    @(posedge pclk);
    lpm_token_valid <= 1'b1;
    lpm_token_hird  <= h;
    @(posedge pclk);
    lpm_token_valid <= 1'b0;
    lpm_token_hird  <= ~h;
  endtask

  // abort completion
  // The engine completes every requested abort bit dly plus one cycles after the request, prompt or slow.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt        <= 0;
      abort_done <= 30'h0;
    end else begin
      abort_done <= 30'h0;
      if (abort_request == 30'h0 || abort_done != 30'h0) begin
        cnt <= 0;
      end else if (cnt >= int'(dly)) begin
        abort_done <= abort_request;
        cnt        <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // ulb_host_model

/* verification/tb_usb_dev_lpm_and_ep_buffer_ctrl.sv */
// Self-checking bench for the link power and endpoint buffer control block.
// Assumes the host model stands on the token and engine side; registers go over APB.
`timescale 1ns/10ps
module tb_usb_dev_lpm_and_ep_buffer_ctrl;
  import ulb_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, d;
  logic        lpm_supported, lpm_token_valid, lpm_hs_valid, lpm_hs_nyet, irq, e;
  logic [3:0]  lpm_token_hird, device_resume_duration, hw_m, sw_m;
  logic [9:0]  nbytes_done, active_buffer_select, double_buffer_enable, sel_m, mode_m;
  logic [29:0] abort_done, abort_request;
  logic [10:0] stat_m;
  logic [7:0]  dly;
  logic        pend_m;
  int          n_mismatch, cmp_count, i, n, k;

  ulb_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lpm_supported(lpm_supported), .lpm_token_valid(lpm_token_valid),
    .lpm_token_hird(lpm_token_hird), .lpm_hs_valid(lpm_hs_valid), .lpm_hs_nyet(lpm_hs_nyet),
    .device_resume_duration(device_resume_duration), .nbytes_done(nbytes_done),
    .abort_done(abort_done), .abort_request(abort_request),
    .active_buffer_select(active_buffer_select),
    .double_buffer_enable(double_buffer_enable), .irq(irq));

  ulb_host_model host (.pclk(pclk), .presetn(presetn), .abort_request(abort_request),
    .dly(dly), .abort_done(abort_done), .lpm_token_valid(lpm_token_valid),
    .lpm_token_hird(lpm_token_hird));

  // Free-running 50 MHz clock.
  always #10 pclk = ~pclk;

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Compares one seen value with the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic err);
    int t;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_mismatch++;
      final_report();
    end
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write and checked register read.
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic        x;
    apb(1'b1, a, wd, r, x);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        x;
    apb(1'b0, a, 32'h0, r, x);
    chk(r, exp);
  endtask

  // Sends a count-zero completion for endpoint n and updates the model.
  task automatic ep_done(input int ep);
    @(posedge pclk);
    nbytes_done <= 10'(1 << ep);
    @(posedge pclk);
    nbytes_done <= 10'h0;
    if (mode_m[ep]) sel_m[ep] = ~sel_m[ep];
    stat_m[ep] = 1'b1;
    @(posedge pclk);
  endtask

  // Hang guard.
  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'hd4ec6a5b));
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    lpm_supported = 0; nbytes_done = 0; dly = 8'h3;
    n_mismatch = 0; cmp_count = 0;
    hw_m = 0; sw_m = 0; pend_m = 0; sel_m = 0; mode_m = 0; stat_m = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(ULB_ADDR_LPC, 32'h0);
    rd_chk(ULB_ADDR_ABORT, 32'h0);
    rd_chk(ULB_ADDR_SEL, 32'h0);
    rd_chk(ULB_ADDR_MODE, 32'h0);
    apb(1'b0, 32'h50000000, 32'h0, d, e);
    chk(e, 1'b1);
    chk(d, 32'h0);
    for (i = 0; i < 4; i++) begin
      d = $urandom();
      wr(ULB_ADDR_LPC, d);
      sw_m = d[7:4];
      pend_m = d[8];
      wr(ULB_ADDR_SEL, d);
      sel_m = d[9:0] & 10'h3fc;
      wr(ULB_ADDR_MODE, ~d);
      mode_m = ~d[9:0] & 10'h3fc;
      rd_chk(ULB_ADDR_LPC, {23'h0, pend_m, sw_m, hw_m});
      rd_chk(ULB_ADDR_SEL, {22'h0, sel_m});
      rd_chk(ULB_ADDR_MODE, {22'h0, mode_m});
      chk({active_buffer_select, double_buffer_enable}, {sel_m, mode_m});
      chk(device_resume_duration, sw_m);
    end
    for (i = 0; i < 6; i++) begin
      @(posedge pclk);
      lpm_supported <= i[0];
      pend_m = i[1];
      wr(ULB_ADDR_LPC, {23'h0, pend_m, sw_m, 4'h0});
      hw_m = 4'($urandom());
      host.send_token(hw_m);
      stat_m[10] = 1'b1;
      @(posedge pclk);
      chk(lpm_hs_valid, i[0]);
      if (i[0]) chk(lpm_hs_nyet, pend_m);
      rd_chk(ULB_ADDR_LPC, {23'h0, pend_m, sw_m, hw_m});
    end
    for (i = 0; i < 20; i++) begin
      ep_done(i % 10);
      chk(active_buffer_select, sel_m);
    end
    rd_chk(ULB_ADDR_IRQ_STAT, {21'h0, stat_m});
    chk(irq, 1'b0);
    wr(ULB_ADDR_IRQ_EN, 32'h7ff);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    wr(ULB_ADDR_MODE, 32'h3fc);
    mode_m = 10'h3fc;
    for (i = 0; i < 4; i++) begin
      wr(ULB_ADDR_IRQ_CLR, 32'h7ff);
      stat_m = 11'h0;
      n = (i == 3) ? 25 : 2 + int'($urandom() % 8);
      dly <= 8'(3 + $urandom() % 5);
      wr(ULB_ADDR_ABORT, 32'(1 << n));
      rd_chk(ULB_ADDR_ABORT, 32'(1 << n));
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (abort_request !== 30'h0 && k < 50);
      chk(k < 50, 1'b1);
      if (k >= 50) final_report();
      if (n < 10) stat_m[n] = 1'b1;
      @(posedge pclk);
      chk(active_buffer_select, sel_m);
      chk(irq, n < 10);
      rd_chk(ULB_ADDR_ABORT, 32'h0);
      rd_chk(ULB_ADDR_IRQ_STAT, {21'h0, stat_m});
    end
    // masked event keeps status but not the line
    wr(ULB_ADDR_IRQ_EN, 32'h0);
    ep_done(5);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    rd_chk(ULB_ADDR_IRQ_STAT, {21'h0, stat_m});
    final_report();
  end
endmodule // tb_usb_dev_lpm_and_ep_buffer_ctrl
